// *** design/tmcp_pkg.sv ***
package tmcp_pkg;
    // ****************************************
    // register selection (register number, select)
    // ****************************************
    localparam logic [4:0] REG_NUM_CONTEXT = 5'h04;
    localparam logic [2:0] SEL_CONTEXT = 3'h0;
    localparam logic [4:0] REG_NUM_THREAD = 5'h04;
    localparam logic [2:0] SEL_THREAD = 3'h2;
    localparam logic [4:0] REG_NUM_TLB_PAGE_SIZE_MASK = 5'h05;
    localparam logic [2:0] SEL_TLB_PAGE_SIZE_MASK = 3'h0;
    localparam logic [4:0] THREAD_POINTER_HW_INDEX = 5'h1D;
    localparam int THREAD_POINTER_READ_ENABLE_BIT = 29;

    // ****************************************
    // field layout
    // ****************************************
    localparam int PTE_BASE_LSB = 23;
    localparam int PTE_BASE_W = 9;
    localparam int MISSED_PAGE_LSB = 4;
    localparam int MISSED_PAGE_W = 19;
    localparam int VADDR_VPN2_LSB = 13;
    localparam int MASK_LSB = 13;
    localparam int MASK_W = 16;
    localparam logic [31:0] CONTEXT_RESET = 32'h0000_0000;
    localparam logic [31:0] THREAD_RESET = 32'h0000_0000;
    localparam logic [MASK_W-1:0] MASK_RESET = 16'h0000;

    // ****************************************
    // carrier types
    // ****************************************
    typedef struct packed {
        logic write;
        logic [4:0] reg_num;
        logic [2:0] sel;
        logic [31:0] wdata;
    } tmcp_cop_access_type;

    typedef struct packed {
        logic miss;
        logic [31:0] vaddr;
    } tmcp_miss_type;

    typedef struct packed {
        logic read;
        logic [4:0] hw_index;
        logic privileged;
        logic [31:0] hw_register_enable_mask;
    } tmcp_hw_read_type;
endpackage : tmcp_pkg

// *** design/tmcp_regs.sv ***
// What this block does
// - Bits 31-23 of the miss-context register hold a software-written table base, kept as written.
// - A TLB miss copies virtual address bits 31-13 into miss-context bits 22-4.
// - Base and missed page together form the address of a 16-byte page table entry.
// - The missed-page field matches the faulting address captured for the same miss.
// - Miss-context bits 3-0 always read zero.
// - The thread-pointer store is a 32-bit read-write word that hardware never alters.
// - An unprivileged hardware-register read of index 29 returns it only if enable bit 29 is set.
// - A TLB read loads the page-size mask from the entry and a TLB write stores it there.
// - Mask bits 28-13 set to one exclude those address bits from TLB matching.
// - Page-size mask bits 31-29 and 12-0 always read zero.
`timescale 1ns/1ps
module tmcp_regs (
    input wire logic clock,
    input wire logic reset,
    input wire tmcp_pkg::tmcp_cop_access_type cop_access,
    output logic [31:0] cop_rdata,
    input wire tmcp_pkg::tmcp_miss_type miss_event,
    input wire tmcp_pkg::tmcp_hw_read_type hw_read,
    output logic [31:0] hw_read_data,
    output logic hw_read_refused,
    input wire logic tlb_read_done,
    input wire logic [tmcp_pkg::MASK_W-1:0] tlb_read_mask,
    output logic tlb_write_valid,
    output logic [tmcp_pkg::MASK_W-1:0] tlb_write_mask,
    input wire logic tlb_write_req,
    output logic [tmcp_pkg::MASK_W-1:0] tlb_compare_mask
);
    // ****************************************
    // state
    // ****************************************
    logic [tmcp_pkg::PTE_BASE_W-1:0] page_table_base_r;
    logic [tmcp_pkg::MISSED_PAGE_W-1:0] missed_page_pair_number_r;
    logic [31:0] thread_pointer_store_r;
    logic [tmcp_pkg::MASK_W-1:0] tlb_page_size_mask_r;

    // ****************************************
    // word geometry
    // ****************************************
    localparam int WORD_W = 32;
    localparam int MASK_HIGH_PAD = WORD_W - tmcp_pkg::MASK_LSB - tmcp_pkg::MASK_W;
    localparam logic [WORD_W-1:0] WORD_ZERO = '0;

    typedef enum {
        TMCP_SEL_NONE,
        TMCP_SEL_CONTEXT,
        TMCP_SEL_THREAD,
        TMCP_SEL_MASK
    } tmcp_read_sel_type;

    // ****************************************
    // field helpers
    // ****************************************
    function automatic logic hit(
        input logic [4:0] num,
        input logic [2:0] sel,
        input logic [4:0] want_num,
        input logic [2:0] want_sel
    );
        hit = (num == want_num) && (sel == want_sel);
    endfunction : hit

    function automatic logic [tmcp_pkg::PTE_BASE_W-1:0] base_field(
        input logic [WORD_W-1:0] word
    );
        base_field = word[tmcp_pkg::PTE_BASE_LSB +: tmcp_pkg::PTE_BASE_W];
    endfunction : base_field

    function automatic logic [tmcp_pkg::MISSED_PAGE_W-1:0] page_field(
        input logic [WORD_W-1:0] word,
        input int lsb
    );
        page_field = word[lsb +: tmcp_pkg::MISSED_PAGE_W];
    endfunction : page_field

    function automatic logic [tmcp_pkg::MASK_W-1:0] mask_field(
        input logic [WORD_W-1:0] word
    );
        mask_field = word[tmcp_pkg::MASK_LSB +: tmcp_pkg::MASK_W];
    endfunction : mask_field

    // ****************************************
    // word builders
    // ****************************************
    // base | page | zero nibble forms a 16-byte aligned entry address
    function automatic logic [WORD_W-1:0] context_word(
        input logic [tmcp_pkg::PTE_BASE_W-1:0] base,
        input logic [tmcp_pkg::MISSED_PAGE_W-1:0] page
    );
        context_word = {base, page, {tmcp_pkg::MISSED_PAGE_LSB{1'h0}}};
    endfunction : context_word

    // unimplemented bits on both sides of the mask read zero
    function automatic logic [WORD_W-1:0] mask_word(
        input logic [tmcp_pkg::MASK_W-1:0] mask
    );
        mask_word = {{MASK_HIGH_PAD{1'h0}}, mask, {tmcp_pkg::MASK_LSB{1'h0}}};
    endfunction : mask_word

    // ****************************************
    // access fields
    // ****************************************
    logic access_write;
    logic [4:0] access_num;
    logic [2:0] access_sel;
    logic [WORD_W-1:0] access_wdata;

    assign access_write = cop_access.write;
    assign access_num = cop_access.reg_num;
    assign access_sel = cop_access.sel;
    assign access_wdata = cop_access.wdata;

    // ****************************************
    // register decode
    // ****************************************
    logic hit_context;
    logic hit_thread;
    logic hit_mask;
    tmcp_read_sel_type read_sel;

    assign hit_context = hit(access_num, access_sel,
        tmcp_pkg::REG_NUM_CONTEXT, tmcp_pkg::SEL_CONTEXT);
    assign hit_thread = hit(access_num, access_sel,
        tmcp_pkg::REG_NUM_THREAD, tmcp_pkg::SEL_THREAD);
    assign hit_mask = hit(access_num, access_sel,
        tmcp_pkg::REG_NUM_TLB_PAGE_SIZE_MASK, tmcp_pkg::SEL_TLB_PAGE_SIZE_MASK);

    // reads ignore the write bit and follow the selection alone
    always_comb begin
        if (hit_context) begin
            read_sel = TMCP_SEL_CONTEXT;
        end else if (hit_thread) begin
            read_sel = TMCP_SEL_THREAD;
        end else if (hit_mask) begin
            read_sel = TMCP_SEL_MASK;
        end else begin
            read_sel = TMCP_SEL_NONE;
        end
    end

    // ****************************************
    // write strobes
    // ****************************************
    logic wr_context;
    logic wr_thread;
    logic wr_mask;

    // writes to unmapped selections vanish
    assign wr_context = access_write && hit_context;
    assign wr_thread = access_write && hit_thread;
    assign wr_mask = access_write && hit_mask;

    // ****************************************
    // page table base
    // ****************************************
    logic [tmcp_pkg::PTE_BASE_W-1:0] written_base;

    assign written_base = base_field(access_wdata);

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            page_table_base_r <= base_field(tmcp_pkg::CONTEXT_RESET);
        end else if (wr_context) begin
            page_table_base_r <= written_base;
        end
    end

    // ****************************************
    // missed page
    // ****************************************
    logic capture_miss;
    logic [tmcp_pkg::MISSED_PAGE_W-1:0] captured_page;

    assign capture_miss = miss_event.miss;
    assign captured_page = page_field(miss_event.vaddr, tmcp_pkg::VADDR_VPN2_LSB);

    // only a miss updates the page field; writes never reach it
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            missed_page_pair_number_r <=
                page_field(tmcp_pkg::CONTEXT_RESET, tmcp_pkg::MISSED_PAGE_LSB);
        end else if (capture_miss) begin
            missed_page_pair_number_r <= captured_page;
        end
    end

    // ****************************************
    // miss-context view
    // ****************************************
    logic [WORD_W-1:0] context_view;

    assign context_view = context_word(page_table_base_r,
        missed_page_pair_number_r);

    // ****************************************
    // thread-pointer store
    // ****************************************
    logic [WORD_W-1:0] written_thread;

    assign written_thread = access_wdata;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            thread_pointer_store_r <= tmcp_pkg::THREAD_RESET;
        end else if (wr_thread) begin
            thread_pointer_store_r <= written_thread;
        end
    end

    // ****************************************
    // thread-pointer view
    // ****************************************
    logic [WORD_W-1:0] thread_view;

    // hardware never touches the word between writes
    assign thread_view = thread_pointer_store_r;

    // ****************************************
    // page-size mask
    // ****************************************
    logic mask_load;
    logic [tmcp_pkg::MASK_W-1:0] written_mask;

    assign mask_load = tlb_read_done;
    assign written_mask = mask_field(access_wdata);

    // a software write outranks a TLB read in the same cycle
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            tlb_page_size_mask_r <= tmcp_pkg::MASK_RESET;
        end else if (wr_mask) begin
            tlb_page_size_mask_r <= written_mask;
        end else if (mask_load) begin
            tlb_page_size_mask_r <= tlb_read_mask;
        end
    end

    // ****************************************
    // page-size mask view
    // ****************************************
    logic [WORD_W-1:0] mask_view;

    assign mask_view = mask_word(tlb_page_size_mask_r);

    // ****************************************
    // TLB exchange
    // ****************************************
    assign tlb_write_valid = tlb_write_req;
    assign tlb_write_mask = tlb_page_size_mask_r;
    // ones drop the matching address bits from the compare
    assign tlb_compare_mask = tlb_page_size_mask_r;

    // ****************************************
    // coprocessor read path
    // ****************************************
    always_comb begin
        unique case (read_sel)
            TMCP_SEL_CONTEXT: begin
                cop_rdata = context_view;
            end
            TMCP_SEL_THREAD: begin
                cop_rdata = thread_view;
            end
            TMCP_SEL_MASK: begin
                cop_rdata = mask_view;
            end
            TMCP_SEL_NONE: begin
                cop_rdata = WORD_ZERO;
            end
        endcase
    end

    // ****************************************
    // hardware-register read decode
    // ****************************************
    logic thread_read;
    logic thread_read_enable;
    logic thread_read_privileged;
    logic thread_read_allowed;

    assign thread_read = hw_read.read &&
        (hw_read.hw_index == tmcp_pkg::THREAD_POINTER_HW_INDEX);
    assign thread_read_enable =
        hw_read.hw_register_enable_mask[tmcp_pkg::THREAD_POINTER_READ_ENABLE_BIT];
    assign thread_read_privileged = hw_read.privileged;
    // privileged reads skip the enable mask
    assign thread_read_allowed = thread_read &&
        (thread_read_privileged || thread_read_enable);

    // ****************************************
    // hardware-register read answer
    // ****************************************
    assign hw_read_refused = thread_read &&
        !thread_read_allowed;

    // refused or foreign reads answer zero
    always_comb begin
        if (thread_read_allowed) begin
            hw_read_data = thread_pointer_store_r;
        end else begin
            hw_read_data = WORD_ZERO;
        end
    end
endmodule : tmcp_regs

// *** test/tmcp_regs_assertions.sv ***
`timescale 1ns/1ps
module tmcp_chk (
    input logic clock,
    input logic reset,
    input tmcp_pkg::tmcp_cop_access_type cop_access,
    input logic [31:0] cop_rdata,
    input tmcp_pkg::tmcp_miss_type miss_event,
    input tmcp_pkg::tmcp_hw_read_type hw_read,
    input logic [31:0] hw_read_data,
    input logic hw_read_refused,
    input logic tlb_read_done,
    input logic [15:0] tlb_read_mask,
    input logic tlb_write_valid,
    input logic [15:0] tlb_write_mask,
    input logic tlb_write_req,
    input logic [15:0] tlb_compare_mask
);
    // ****
    // port relations
    // ****
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    wire logic [7:0] a = {cop_access.reg_num, cop_access.sel};
    wire logic c = a == 8'h20;
    wire logic t = a == 8'h22;
    wire logic m = a == 8'h28;
    wire logic w = cop_access.write;
    wire logic u = hw_read.read && hw_read.hw_index == 5'h1D && !hw_read.privileged;
    wire logic e = hw_read.hw_register_enable_mask[29];
    wire logic [18:0] vpn = miss_event.vaddr[31:13];
    wire logic [8:0] base_w = cop_access.wdata[31:23];
    sequence s_miss; miss_event.miss ##1 c; endsequence
    sequence s_base; w && c ##1 c; endsequence
    sequence s_thr; w && t ##1 t; endsequence
    sequence s_keep; w && c && !miss_event.miss ##1 c; endsequence
    a_ctx_low_zero: assert property (c |-> cop_rdata[3:0] == 4'h0)
        else $error("ctx low");
    a_miss_capture: assert property (s_miss |-> cop_rdata[22:4] == $past(vpn))
        else $error("miss");
    a_base_kept: assert property (s_base |-> cop_rdata[31:23] == $past(base_w))
        else $error("base");
    a_page_ro: assert property (s_keep |-> cop_rdata[22:4] == $past(cop_rdata[22:4]))
        else $error("page written");
    a_thread_kept: assert property (s_thr |-> cop_rdata == $past(cop_access.wdata))
        else $error("thread");
    a_hw_refuse: assert property (u && !e |-> hw_read_refused && hw_read_data == 32'h0)
        else $error("refuse");
    a_hw_allow: assert property (
        u && e && t |-> !hw_read_refused && hw_read_data == cop_rdata)
        else $error("allow");
    a_tlb_load: assert property (
        tlb_read_done && !(w && m) |=> tlb_write_mask == $past(tlb_read_mask))
        else $error("tlb load");
    a_tlb_store: assert property (
        tlb_write_req && m |-> tlb_write_valid && tlb_write_mask == cop_rdata[28:13])
        else $error("tlb store");
    a_tlb_idle: assert property (!tlb_write_req |-> !tlb_write_valid)
        else $error("tlb idle");
    a_mask_zero: assert property (
        m |-> cop_rdata == {3'h0, tlb_compare_mask, 13'h0})
        else $error("mask");
endmodule : tmcp_chk
bind tmcp_regs tmcp_chk i_tmcp_chk (.*);

// *** test/tb.sv ***
`timescale 1ns/1ps
module tb;
    // ****
    // scenarios
    // ****
    localparam logic [31:0] VA = 32'hABCDE123;
    logic clock = 1'b0, reset = 1'b1, trd = 1'b0, twr = 1'b0, rf, wv;
    tmcp_pkg::tmcp_cop_access_type ca = '0;
    tmcp_pkg::tmcp_miss_type me = '0;
    tmcp_pkg::tmcp_hw_read_type hr = '0;
    logic [15:0] trm = 16'h0000, wm, cm;
    logic [31:0] rd, hd, p;
    int n_fail = 0, n_compared = 0;
    tmcp_regs i_tmcp_regs (.clock(clock), .reset(reset), .cop_access(ca), .cop_rdata(rd),
        .miss_event(me), .hw_read(hr), .hw_read_data(hd), .hw_read_refused(rf),
        .tlb_read_done(trd), .tlb_read_mask(trm), .tlb_write_valid(wv),
        .tlb_write_mask(wm), .tlb_write_req(twr), .tlb_compare_mask(cm));
    initial begin
        forever #2.5 clock = ~clock;
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %0t: got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        ca <= {w, a, d};
        #1;
    endtask : acc
    task automatic t_ctx;
        @(posedge clock);
        me <= {1'b1, VA};
        ca <= {1'b1, 8'h20, 32'hFFFFFFFF};
        @(posedge clock);
        me <= '0;
        acc(0, 8'h20, 32'h0);
        cmp(rd, {9'h1FF, VA[31:13], 4'h0});
        acc(1, 8'h20, 32'h0);
        acc(0, 8'h20, 32'h0);
        cmp(rd, {9'h000, VA[31:13], 4'h0});
    endtask : t_ctx
    task automatic t_mask;
        acc(1, 8'h28, 32'hFFFFFFFF);
        acc(0, 8'h28, 32'h0);
        cmp(rd, 32'h1FFFE000);
        for (int k = 0; k < 9; k++) begin
            p = (32'h1 << (2 * k)) - 32'h1;
            acc(1, 8'h28, {3'h0, p[15:0], 13'h0});
            acc(0, 8'h28, 32'h0);
            cmp({16'h0, cm}, {16'h0, p[15:0]});
        end
        @(posedge clock);
        trd <= 1'b1;
        trm <= 16'h00FF;
        @(posedge clock);
        trd <= 1'b0;
        twr <= 1'b1;
        #1;
        cmp({15'h0, wv, wm}, {15'h0, 1'b1, 16'h00FF});
        @(posedge clock);
        twr <= 1'b0;
        #1;
        cmp({31'h0, wv}, 32'h0);
    endtask : t_mask
    task automatic t_hw;
        acc(1, 8'h22, 32'hA5A5F00F);
        for (int i = 0; i < 4; i++) begin
            @(posedge clock);
            hr <= {1'b1, 5'h1D, i[1], (i[0] ? 32'h20000000 : 32'h0)};
            ca <= {1'b0, 8'h22, 32'h0};
            #1;
            cmp(hd, (i[1] | i[0]) ? 32'hA5A5F00F : 32'h0);
            cmp({31'h0, rf}, {31'h0, !(i[1] | i[0])});
        end
    endtask : t_hw
    task automatic conclude;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        acc(0, 8'h38, 32'h0);
        cmp(rd, 32'h0);
        t_ctx();
        t_mask();
        t_hw();
        conclude();
    end
endmodule : tb
